// ==== src/bsf_unit.sv ====
// bsf_unit.sv: shift, bit transfer and flag unit with apb register access
// assumes: apb master on sys_clk; sleep and watchdog logic outside
`timescale 1ns/1ps
`include "bsf_cfg.svh"

// Notes on behaviour
// - rotate left moves bits up, old carry to bit 0, bit 7 to carry, one cycle.
// - rotate right moves bits down, old carry to bit 7, bit 0 to carry.
// - arithmetic shift right keeps the sign bit, bit 0 goes to carry.
// - bit-to-transfer copies the selected operand bit into T only.
// - transfer-to-bit writes T into the selected operand bit only.
// - overflow set and clear force V and nothing else, one cycle.
// - sign set and clear force S and nothing else, one cycle.
// - half-carry set and clear force H and nothing else, one cycle.
// - sleep gives a one-cycle request and leaves the flags alone.
// - watchdog restart gives a one-cycle pulse and leaves the flags alone.
module bsf_unit
    import bsf_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // to sleep controller and watchdog
    output logic             sleep_req,
    output logic             wdog_restart
);

    typedef struct packed
    {
        logic [7:0]  operand;
        logic [7:0]  flags;
        logic [3:0]  last_op;
        logic [2:0]  last_bit;
        logic [31:0] rdata;
        logic [15:0] op_count;
    } bsf_state_t;

    bsf_state_t   st_reg;
    bsf_state_t   st_next;
    bsf_alu_out_t alu_res;
    logic [3:0]   cmd_op;
    logic [2:0]   cmd_bit;
    logic         wr_acc;
    logic         cmd_fire;
    logic         sleep_fire;
    logic         wdog_fire;

    // access phase completes in one cycle, pready never stalls
    assign wr_acc  = psel && penable && pwrite;
    assign cmd_op  = pwdata[`BSF_CMD_OP_MSB:`BSF_CMD_OP_LSB];
    assign cmd_bit = pwdata[`BSF_CMD_BIT_MSB:`BSF_CMD_BIT_LSB];
    assign cmd_fire = wr_acc && (paddr == `BSF_OFF_CMD) && pstrb[0];

    function automatic logic mapped(input logic [11:0] a);
        return (a == `BSF_OFF_OPERAND) || (a == `BSF_OFF_CMD) ||
               (a == `BSF_OFF_FLAGS) || (a == `BSF_OFF_RESULT) ||
               (a == `BSF_OFF_STATUS);
    endfunction

    bsf_alu u_alu
    (
        .op       (cmd_op),
        .bit_sel  (cmd_bit),
        .data_in  (st_reg.operand),
        .flags_in (st_reg.flags),
        .res      (alu_res)
    );

    assign sleep_fire = cmd_fire && (cmd_op == sleep_op);
    assign wdog_fire  = cmd_fire && (cmd_op == watchdog_restart_op);

    // registered strobes; flags are untouched by these ops in the alu
    bsf_pulse u_sleep
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fire    (sleep_fire),
        .strobe  (sleep_req)
    );

    bsf_pulse u_wdog
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fire    (wdog_fire),
        .strobe  (wdog_restart)
    );

    always_comb
    begin
        st_next = st_reg;
        if (wr_acc)
        begin
            // unmapped offsets match none of these and are dropped
            if (paddr == `BSF_OFF_OPERAND && pstrb[0])
                st_next.operand = pwdata[7:0];
            else if (paddr == `BSF_OFF_FLAGS && pstrb[0])
                st_next.flags = pwdata[7:0];
            else if (cmd_fire)
            begin
                // single-cycle execution: result lands at this edge
                st_next.operand  = alu_res.data;
                st_next.flags    = alu_res.flags;
                st_next.last_op  = cmd_op;
                st_next.last_bit = cmd_bit;
                st_next.op_count = st_reg.op_count + 16'h0001;
            end
        end
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `BSF_OFF_OPERAND: st_next.rdata = {24'h0, st_reg.operand};
                `BSF_OFF_FLAGS:   st_next.rdata = {24'h0, st_reg.flags};
                `BSF_OFF_RESULT:  st_next.rdata = {24'h0, st_reg.operand};
                `BSF_OFF_CMD:
                    st_next.rdata = {21'h0, st_reg.last_bit, 4'h0,
                                     st_reg.last_op};
                `BSF_OFF_STATUS:  st_next.rdata = {16'h0, st_reg.op_count};
                default:          st_next.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.flags <= `BSF_FLAGS_RST;
            st_reg.operand <= `BSF_DATA_RST;
        end
        else
            st_reg <= st_next;
    end

    assign pready  = 1'b1;
    assign prdata  = st_reg.rdata;
    assign pslverr = psel && penable && !mapped(paddr);

endmodule

// ==== src/bsf_cfg.svh ====
// bsf_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the package and modules of bsf
`ifndef BSF_CFG_SVH
`define BSF_CFG_SVH

// register byte offsets on the apb bus
`define BSF_OFF_OPERAND   12'h000
`define BSF_OFF_CMD       12'h004
`define BSF_OFF_FLAGS     12'h008
`define BSF_OFF_RESULT    12'h00c
`define BSF_OFF_STATUS    12'h010

// flag word bit positions
`define BSF_FLAG_C        0
`define BSF_FLAG_Z        1
`define BSF_FLAG_N        2
`define BSF_FLAG_V        3
`define BSF_FLAG_S        4
`define BSF_FLAG_H        5
`define BSF_FLAG_T        6
`define BSF_FLAG_I        7

// command register fields
`define BSF_CMD_OP_LSB    0
`define BSF_CMD_OP_MSB    3
`define BSF_CMD_BIT_LSB   8
`define BSF_CMD_BIT_MSB   10

// reset values
`define BSF_FLAGS_RST     8'h00
`define BSF_DATA_RST      8'h00

// every operation takes this many cycles
`define BSF_OP_CYCLES     1

`endif

// ==== src/bsf_pkg.sv ====
// bsf_pkg.sv: types shared by the bit shift and flag unit
// assumes: bsf_cfg.svh is on the include path
`include "bsf_cfg.svh"

package bsf_pkg;

    typedef enum logic [3:0]
    {
        nop_op                    = 4'h0,
        rotate_left_via_carry_op  = 4'h1,
        rotate_right_via_carry_op = 4'h2,
        arith_shift_right_op      = 4'h3,
        bit_to_transfer_flag_op   = 4'h4,
        transfer_flag_to_bit_op   = 4'h5,
        overflow_flag_set_op      = 4'h6,
        overflow_flag_clear_op    = 4'h7,
        sign_flag_set_op          = 4'h8,
        sign_flag_clear_op        = 4'h9,
        half_carry_set_op         = 4'ha,
        half_carry_clear_op       = 4'hb,
        sleep_op                  = 4'hc,
        watchdog_restart_op       = 4'hd
    } bsf_op_t;

    typedef struct packed
    {
        logic [7:0] data;
        logic [7:0] flags;
    } bsf_alu_out_t;

endpackage

// ==== src/bsf_alu.sv ====
// bsf_alu.sv: combinational shift and flag datapath for one operation
// assumes: driven by registered operand and flag word, and by command fields taken straight from pwdata
`timescale 1ns/1ps
`include "bsf_cfg.svh"

module bsf_alu
    import bsf_pkg::*;
(
    // operation
    input  wire logic [3:0]   op,
    input  wire logic [2:0]   bit_sel,
    // state in
    input  wire logic [7:0]   data_in,
    input  wire logic [7:0]   flags_in,
    // result
    output bsf_alu_out_t      res
);

    // shared z/n/v update after any rotate or shift
    function automatic logic [7:0] shift_flags(
        input logic [7:0] f,
        input logic [7:0] r,
        input logic       c
    );
        logic [7:0] o;
        o = f;
        o[`BSF_FLAG_C] = c;
        o[`BSF_FLAG_Z] = (r == 8'h00);
        o[`BSF_FLAG_N] = r[7];
        o[`BSF_FLAG_V] = r[7] ^ c;
        return o;
    endfunction

    always_comb
    begin
        logic [7:0] r;
        r = data_in;
        res.data = data_in;
        res.flags = flags_in;
        unique case (op)
            rotate_left_via_carry_op:
            begin
                r = {data_in[6:0], flags_in[`BSF_FLAG_C]};
                res.data = r;
                res.flags = shift_flags(flags_in, r, data_in[7]);
            end
            rotate_right_via_carry_op:
            begin
                r = {flags_in[`BSF_FLAG_C], data_in[7:1]};
                res.data = r;
                res.flags = shift_flags(flags_in, r, data_in[0]);
            end
            arith_shift_right_op:
            begin
                r = {data_in[7], data_in[7:1]};
                res.data = r;
                res.flags = shift_flags(flags_in, r, data_in[0]);
            end
            bit_to_transfer_flag_op:
                res.flags[`BSF_FLAG_T] = data_in[bit_sel];
            transfer_flag_to_bit_op:
                res.data[bit_sel] = flags_in[`BSF_FLAG_T];
            overflow_flag_set_op:
                res.flags[`BSF_FLAG_V] = 1'b1;
            overflow_flag_clear_op:
                res.flags[`BSF_FLAG_V] = 1'b0;
            sign_flag_set_op:
                res.flags[`BSF_FLAG_S] = 1'b1;
            sign_flag_clear_op:
                res.flags[`BSF_FLAG_S] = 1'b0;
            half_carry_set_op:
                res.flags[`BSF_FLAG_H] = 1'b1;
            half_carry_clear_op:
                res.flags[`BSF_FLAG_H] = 1'b0;
            default:
            begin
                res.data = data_in;
                res.flags = flags_in;
            end
        endcase
    end

endmodule

// ==== src/bsf_pulse.sv ====
// bsf_pulse.sv: one-cycle strobe generator for the control operations
// assumes: fire is a single-cycle request on sys_clk
`timescale 1ns/1ps

module bsf_pulse
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // request
    input  wire logic fire,
    // strobe
    output logic      strobe
);

    typedef struct packed
    {
        logic q;
    } bsf_pulse_state_t;

    bsf_pulse_state_t st_reg;
    bsf_pulse_state_t st_next;

    always_comb
    begin
        st_next = st_reg;
        st_next.q = fire;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign strobe = st_reg.q;

endmodule

// ==== testbench/bsf_unit_chk.sv ====
// bsf_unit_chk.sv: port assertions for the shift and flag unit
// assumes: bound to bsf_unit, single clock sys_clk
`timescale 1ns/1ps

module bsf_unit_chk
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pulses
    input wire logic        sleep_req,
    input wire logic        wdog_restart
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire cw = psel && penable && pwrite && pstrb[0] && paddr == 12'h004;
    wire acc = psel && penable;

    a_sleep_pulse:
    assert property (cw && pwdata[3:0] == 4'hc |=> sleep_req)
        else $error("sleep request missing");
    a_sleep_cause:
    assert property (sleep_req |-> $past(cw && pwdata[3:0] == 4'hc))
        else $error("sleep request without command");
    a_sleep_single:
    assert property (sleep_req |=> !sleep_req)
        else $error("sleep request longer than one cycle");
    a_wdog_pulse:
    assert property (cw && pwdata[3:0] == 4'hd |=> wdog_restart)
        else $error("watchdog restart missing");
    a_wdog_cause:
    assert property (wdog_restart |-> $past(cw && pwdata[3:0] == 4'hd))
        else $error("watchdog restart without command");
    a_wdog_single:
    assert property (wdog_restart |=> !wdog_restart)
        else $error("watchdog restart longer than one cycle");
    a_err_unmapped:
    assert property (acc && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped:
    assert property (acc && paddr <= 12'h010 && paddr[1:0] == 0 |-> !pslverr)
        else $error("mapped access refused");

    cover property (sleep_req);
    cover property (wdog_restart);
    cover property (acc && pslverr);
endmodule

bind bsf_unit bsf_unit_chk bsf_unit_chk_i (.sys_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_req,
    .wdog_restart);

// ==== testbench/bsf_pwr_model.sv ====
// bsf_pwr_model.sv: sleep controller and watchdog stand-in, counts pulses
// assumes: pulses are one cycle wide on sys_clk
`timescale 1ns/1ps

module bsf_pwr_model
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // pulses in
    input  wire logic sleep_req,
    input  wire logic wdog_restart,
    // counts
    output int        n_sleep,
    output int        n_wdog
);
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            n_sleep <= 0;
            n_wdog <= 0;
        end
        else
        begin
            n_sleep <= n_sleep + sleep_req;
            n_wdog <= n_wdog + wdog_restart;
        end
    end
endmodule

// ==== testbench/test_bsf_unit.sv ====
// test_bsf_unit.sv: apb driven checks of shifts, bit moves, flags, pulses
// assumes: bsf_unit, its checker and the power model compiled first
`timescale 1ns/1ps

module test_bsf_unit;
    logic        sys_clk = 0;
    logic        rst_n = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0]  pstrb = 4'hf;
    logic [3:0]  strb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sleep_req;
    logic        wdog_restart;
    logic [31:0] rq;
    logic        eq;
    int          n_sleep;
    int          n_wdog;
    int          errors = 0;
    int          n_checks = 0;
    logic [7:0]  d;
    logic [7:0]  f;
    logic [15:0] e;
    logic [7:0]  pat [4] = '{8'h80, 8'h01, 8'h00, 8'hc3};

    always #2 sys_clk = ~sys_clk;
    // answer taken with the values of the access edge itself
    always @(posedge sys_clk)
    begin
        rq <= prdata;
        eq <= pslverr;
    end

    bsf_unit bsf_unit_i (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .sleep_req,
        .wdog_restart);
    bsf_pwr_model bsf_pwr_model_i (.sys_clk, .rst_n, .sleep_req,
        .wdog_restart, .n_sleep, .n_wdog);

    task chk(input string nm, input [31:0] exp, input [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task acc(input logic w, input [11:0] a, input [31:0] v);
        @(posedge sys_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        pstrb <= strb;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        psel <= 0;
        penable <= 0;
        #1;
    endtask

    task rdc(input [11:0] a, input string nm, input [7:0] exp);
        acc(0, a, 0);
        chk(nm, {24'h0, exp}, rq);
    endtask

    function logic [15:0] shx(input int op, input [7:0] v, input [7:0] g);
        logic [7:0] r;
        logic       c;
        if (op == 1)
            {c, r} = {v, g[0]};
        else if (op == 2)
            {r, c} = {g[0], v};
        else
            {r, c} = {v[7], v};
        g[0] = c;
        g[1] = r == 0;
        g[2] = r[7];
        g[3] = r[7] ^ c;
        return {g, r};
    endfunction

    task results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        errors++;
        results;
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1;
        for (int op = 1; op < 4; op++)
            for (int i = 0; i < 4; i++)
                for (int c = 0; c < 2; c++)
                begin
                    f = 8'h70 | c;
                    e = shx(op, pat[i], f);
                    acc(1, 12'h000, pat[i]);
                    acc(1, 12'h008, f);
                    acc(1, 12'h004, op);
                    rdc(12'h000, "shift data", e[7:0]);
                    rdc(12'h008, "shift flags", e[15:8]);
                end
        for (int op = 6; op < 12; op++)
            for (int k = 0; k < 2; k++)
            begin
                f = {8{k[0]}};
                acc(1, 12'h008, f);
                acc(1, 12'h004, op);
                f[3 + (op - 6) / 2] = ~op[0];
                rdc(12'h008, "flag op", f);
            end
        d = 8'ha6;
        for (int b = 0; b < 8; b++)
        begin
            f = 8'hbf;
            acc(1, 12'h000, d);
            acc(1, 12'h008, f);
            acc(1, 12'h004, (b << 8) | 4);
            f[6] = d[b];
            rdc(12'h008, "bit to t", f);
            f[6] = ~f[6];
            acc(1, 12'h008, f);
            acc(1, 12'h004, (b << 8) | 5);
            d[b] = f[6];
            rdc(12'h000, "t to bit data", d);
            rdc(12'h008, "t to bit flags", f);
        end
        acc(1, 12'h008, 8'h2c);
        acc(1, 12'h004, 4'hc);
        acc(1, 12'h004, 4'hd);
        acc(1, 12'h004, 4'h0);
        rdc(12'h008, "pulse flags", 8'h2c);
        chk("sleep count", 1, n_sleep);
        chk("restart count", 1, n_wdog);
        strb = 4'h0;
        acc(1, 12'h000, 8'h5a);
        strb = 4'hf;
        rdc(12'h000, "masked write", d);
        rdc(12'h00c, "result alias", d);
        rdc(12'h010, "op count", 8'h37);
        acc(0, 12'h020, 0);
        chk("unmapped err", 1, eq);
        chk("unmapped data", 0, rq);
        results;
    end
endmodule
